// *** rtl/ssr_pkg.sv ***
// Purpose: constants for the synchronous slave serial receiver
// Assumes: AHB-Lite slave, 32-bit words, one register per aligned word
// Notes: bit positions are those of the 8-bit control registers
// Summary of operation
// - Slave receive as master; single-receive bit ignored
// - Continuous receive keeps working in low power
// - Completed word moves from shifter to buffer
// - Enabled receive interrupt wakes from low power
// - Slave when sync, port enable, external clock
// - Clock polarity bit inverts incoming shift clock
// - Data polarity bit inverts incoming serial data
// - Nine-bit bit adds a ninth received bit
// - Receiving only while continuous receive set
// - Word sets flag; interrupt only if enabled
// - Status shows ninth bit and error flags
// - Buffer read returns the eight data bits
// - Clearing continuous receive clears error flags
// - Interrupt needs global and peripheral enables
package ssr_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_RCV_STAT = 8'h00;
  localparam logic [7:0] ADDR_RCV_BUF = 8'h04;
  localparam logic [7:0] ADDR_TX_STAT = 8'h08;
  localparam logic [7:0] ADDR_LINE_CTL = 8'h0c;
  localparam logic [7:0] ADDR_INT_CTL = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h18;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h1c;
  localparam logic [7:0] ADDR_POWER = 8'h20;
  // receive_status_control fields
  localparam int RS_PORT_EN = 7;
  localparam int RS_NINE = 6;
  localparam int RS_SINGLE = 5;
  localparam int RS_CONT = 4;
  localparam int RS_ADDR_DET = 3;
  localparam int RS_FRAMING_ERROR_FLAG = 2;
  localparam int RS_OVERRUN_ERROR_FLAG = 1;
  localparam int RS_NINTH = 0;
  // transmit_status_control, line_control, interrupt_control fields
  localparam int TS_CLK_SRC = 7;
  localparam int TS_SYNC = 4;
  localparam int LC_DATA_INV = 5;
  localparam int LC_CLK_INV = 4;
  localparam int IC_GIE = 7;
  localparam int IC_PERIPHERAL_INTERRUPT_ENABLE = 6;
  // Interrupt status bits
  localparam int IRQ_RX = 0;
  localparam int IRQ_OVR = 1;
  localparam int IRQ_W = 2;
  localparam int PWR_SLEEP = 0;
  // Bit counter values for last bit of a word
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [7:0] REG_RESET = 8'h00;
endpackage

// *** rtl/ssr_top.sv ***
// Purpose: receive path of a synchronous slave serial port with AHB-Lite registers
// Assumes: hclk 20 MHz, shift clock far slower (several hclk per half period)
// Notes: link pins pass two flops; reads take one wait state, writes none
`timescale 1ns/100ps
module ssr_top import ssr_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic shift_clock_pin,
  input wire logic serial_data_pin,
  output logic irq,
  output logic wake,
  output logic low_power
);
  // Control registers
  logic [7:0] rcv_ctl_ff;
  logic [7:0] tx_ctl_ff;
  logic [7:0] line_ctl_ff;
  logic [7:0] int_ctl_ff;
  logic [IRQ_W-1:0] ist_ff, ien_ff;
  logic sleep_ff;
  // Bus state
  logic wr_pend_ff, rd_pend_ff;
  logic [7:0] wr_addr_ff, rd_addr_ff;
  logic hreadyout_ff, hresp_ff, irq_ff, wake_ff;
  logic [31:0] hrdata_ff;
  // Receive datapath
  logic [2:0] sck_sync_ff;
  logic [1:0] sdat_sync_ff;
  logic [8:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] rxbuf_ff;
  logic received_ninth_bit_ff, full_ff, ovr_ff;

  assign hreadyout = hreadyout_ff;
  assign hrdata = hrdata_ff;
  assign hresp = hresp_ff;
  assign irq = irq_ff;
  assign wake = wake_ff;
  assign low_power = sleep_ff;

  // Address phase decode; only accepted when the bus is ready
  wire addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire wr_take = addr_ok & hwrite;
  wire rd_take = addr_ok & ~hwrite;
  wire rd_done = rd_pend_ff;
  wire rd_buf = rd_done & (rd_addr_ff == ADDR_RCV_BUF);

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = wr_pend_ff & (wr_addr_ff == a);
  endfunction

  wire slave_mode = rcv_ctl_ff[RS_PORT_EN] & tx_ctl_ff[TS_SYNC] & ~tx_ctl_ff[TS_CLK_SRC];
  // low power not in the term
  wire rx_active = slave_mode & rcv_ctl_ff[RS_CONT];
  wire nine = rcv_ctl_ff[RS_NINE];

  wire clk_now = sck_sync_ff[1] ^ line_ctl_ff[LC_CLK_INV];
  wire clk_prev = sck_sync_ff[2] ^ line_ctl_ff[LC_CLK_INV];
  wire clk_rise = clk_now & ~clk_prev;
  wire rx_bit = sdat_sync_ff[1] ^ line_ctl_ff[LC_DATA_INV];
  wire take_bit = rx_active & clk_rise;
  wire last_bit = bit_cnt_ff == (nine ? LAST_BIT_9 : LAST_BIT_8);
  wire [8:0] nxt_shift = {rx_bit, shift_ff[8:1]};
  wire word_done = take_bit & last_bit;
  wire [7:0] word_data = nine ? nxt_shift[7:0] : nxt_shift[8:1];
  wire word_ninth = nine & nxt_shift[8];
  // A word finding the buffer still unread is dropped as overrun
  wire buf_free = ~full_ff | rd_buf;
  wire load_buf = word_done & buf_free;
  wire ovr_set = word_done & ~buf_free;
  wire [3:0] nxt_bit_cnt = (~rx_active | word_done) ? 4'h0 : (take_bit ? 4'(bit_cnt_ff + 4'h1) : bit_cnt_ff);

  wire nxt_ovr = ovr_set | (ovr_ff & rcv_ctl_ff[RS_CONT]);
  // receive flag set, set beats clear
  wire [IRQ_W-1:0] ist_clr = wr_hit(ADDR_IRQ_CLR) ? hwdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] ist_set;
  assign ist_set[IRQ_RX] = load_buf;
  assign ist_set[IRQ_OVR] = ovr_set;
  wire [IRQ_W-1:0] nxt_ist = ist_set | (ist_ff & ~ist_clr);
  wire pend = |(ist_ff & ien_ff);
  wire nxt_irq = pend & int_ctl_ff[IC_GIE] & int_ctl_ff[IC_PERIPHERAL_INTERRUPT_ENABLE];
  wire wake_ev = sleep_ff & pend;
  wire nxt_sleep = wr_hit(ADDR_POWER) ? hwdata[PWR_SLEEP] : (sleep_ff & ~wake_ev);

  // status byte with ninth bit and errors
  // Framing never sets: a clocked link has no stop bit to check
  wire [7:0] rcv_stat_rd;
  assign rcv_stat_rd[RS_PORT_EN:RS_ADDR_DET] = rcv_ctl_ff[RS_PORT_EN:RS_ADDR_DET];
  assign rcv_stat_rd[RS_FRAMING_ERROR_FLAG] = 1'b0;
  assign rcv_stat_rd[RS_OVERRUN_ERROR_FLAG] = ovr_ff;
  assign rcv_stat_rd[RS_NINTH] = received_ninth_bit_ff;
  wire [7:0] rd_byte =
    (rd_addr_ff == ADDR_RCV_STAT) ? rcv_stat_rd :
    (rd_addr_ff == ADDR_RCV_BUF) ? rxbuf_ff :
    (rd_addr_ff == ADDR_TX_STAT) ? tx_ctl_ff :
    (rd_addr_ff == ADDR_LINE_CTL) ? line_ctl_ff :
    (rd_addr_ff == ADDR_INT_CTL) ? int_ctl_ff :
    (rd_addr_ff == ADDR_IRQ_STAT) ? {6'h00, ist_ff} :
    (rd_addr_ff == ADDR_IRQ_EN) ? {6'h00, ien_ff} :
    (rd_addr_ff == ADDR_POWER) ? {7'h00, sleep_ff} : 8'h00;

  // Link pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sck_sync_ff <= 3'h0;
      sdat_sync_ff <= 2'h0;
    end else begin
      sck_sync_ff <= {sck_sync_ff[1:0], shift_clock_pin};
      sdat_sync_ff <= {sdat_sync_ff[0], serial_data_pin};
    end
  end

  // Shifter and bit counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_ff <= 9'h000;
      bit_cnt_ff <= 4'h0;
    end else begin
      bit_cnt_ff <= nxt_bit_cnt;
      if (take_bit) begin
        shift_ff <= nxt_shift;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxbuf_ff <= REG_RESET;
      received_ninth_bit_ff <= 1'b0;
      full_ff <= 1'b0;
      ovr_ff <= 1'b0;
    end else begin
      ovr_ff <= nxt_ovr;
      if (load_buf) begin
        rxbuf_ff <= word_data;
        received_ninth_bit_ff <= word_ninth;
        full_ff <= 1'b1;
      end else if (rd_buf) begin
        full_ff <= 1'b0;
      end
    end
  end

  // Interrupt status, line and wake
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ist_ff <= '0;
      irq_ff <= 1'b0;
      wake_ff <= 1'b0;
      sleep_ff <= 1'b0;
    end else begin
      ist_ff <= nxt_ist;
      irq_ff <= nxt_irq;
      wake_ff <= wake_ev;
      sleep_ff <= nxt_sleep;
    end
  end

  // Software writes land at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rcv_ctl_ff <= REG_RESET;
      tx_ctl_ff <= REG_RESET;
      line_ctl_ff <= REG_RESET;
      int_ctl_ff <= REG_RESET;
      ien_ff <= '0;
    end else begin
      // Flags in the low three bits are read-only
      if (wr_hit(ADDR_RCV_STAT)) begin
        rcv_ctl_ff[RS_PORT_EN:RS_ADDR_DET] <= hwdata[RS_PORT_EN:RS_ADDR_DET];
      end
      if (wr_hit(ADDR_TX_STAT)) begin
        tx_ctl_ff[TS_CLK_SRC] <= hwdata[TS_CLK_SRC];
        tx_ctl_ff[TS_SYNC] <= hwdata[TS_SYNC];
      end
      if (wr_hit(ADDR_LINE_CTL)) begin
        line_ctl_ff[LC_DATA_INV] <= hwdata[LC_DATA_INV];
        line_ctl_ff[LC_CLK_INV] <= hwdata[LC_CLK_INV];
      end
      if (wr_hit(ADDR_INT_CTL)) begin
        int_ctl_ff[IC_GIE] <= hwdata[IC_GIE];
        int_ctl_ff[IC_PERIPHERAL_INTERRUPT_ENABLE] <= hwdata[IC_PERIPHERAL_INTERRUPT_ENABLE];
      end
      if (wr_hit(ADDR_IRQ_EN)) begin
        ien_ff <= hwdata[IRQ_W-1:0];
      end
    end
  end

  // Bus phases; read data is registered so reads stall one cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rd_addr_ff <= 8'h00;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
      hresp_ff <= 1'b0;
    end else begin
      wr_pend_ff <= wr_take;
      rd_pend_ff <= rd_take;
      if (addr_ok) begin
        wr_addr_ff <= haddr[7:0];
        rd_addr_ff <= haddr[7:0];
      end
      hreadyout_ff <= ~rd_take;
      if (rd_done) begin
        hrdata_ff <= {24'h000000, rd_byte};
      end
    end
  end

  // Helper: sleep was set one cycle earlier
  logic sleep_d_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_d_ff <= 1'b0;
    end else begin
      sleep_d_ff <= sleep_ff;
    end
  end

  // Shadow count of bits taken, apart from the shifter's counter, so a broken count is caught
  logic [3:0] seen_bits_ff;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_bits_ff <= 4'h0;
    end else if (!rx_active || word_done) begin
      seen_bits_ff <= 4'h0;
    end else if (take_bit) begin
      seen_bits_ff <= 4'(seen_bits_ff + 4'h1);
    end
  end

  // Checks on the receive path and bus answer
  // Completed word lands in the buffer
  a_word_loads_buf: assert property (@(posedge hclk) disable iff (!hresetn)
    load_buf |=> (rxbuf_ff == $past(word_data)) && full_ff)
    else $error("completed word not in buffer");

  // Counter parked while receive is off
  a_idle_no_shift: assert property (@(posedge hclk) disable iff (!hresetn)
    !rx_active |=> bit_cnt_ff == 4'h0)
    else $error("bit counter moved while receive off");

  // Bits only taken in slave mode
  a_slave_needs_bits: assert property (@(posedge hclk) disable iff (!hresetn)
    take_bit |-> rcv_ctl_ff[RS_PORT_EN] && tx_ctl_ff[TS_SYNC] && !tx_ctl_ff[TS_CLK_SRC])
    else $error("bit taken outside slave mode");

  // Dropping continuous receive clears the error
  a_cont_clears_err: assert property (@(posedge hclk) disable iff (!hresetn)
    !rcv_ctl_ff[RS_CONT] |=> !ovr_ff)
    else $error("overrun flag kept with receive off");

  // Flag follows every loaded word
  a_flag_on_word: assert property (@(posedge hclk) disable iff (!hresetn)
    load_buf |=> ist_ff[IRQ_RX])
    else $error("receive flag not set after word");

  // Line needs global and peripheral enables
  a_irq_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    irq_ff |-> $past(int_ctl_ff[IC_GIE]) && $past(int_ctl_ff[IC_PERIPHERAL_INTERRUPT_ENABLE]) && $past(pend))
    else $error("interrupt without both enables");

  // Enabled event ends low power
  a_wake_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    (sleep_ff && ist_ff[IRQ_RX] && ien_ff[IRQ_RX] && !wr_hit(ADDR_POWER)) |=> wake_ff && !sleep_ff)
    else $error("enabled receive event did not wake");

  // Word closes after eight or nine bits
  a_word_length: assert property (@(posedge hclk) disable iff (!hresetn)
    word_done |-> seen_bits_ff == (nine ? LAST_BIT_9 : LAST_BIT_8))
    else $error("word closed at wrong bit count");

  // Reads answer after one wait
  a_read_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_take |=> !hreadyout_ff ##1 hreadyout_ff)
    else $error("read answer not after one wait");

  // Shifter keeps taking bits in low power
  a_sleep_rx_ok: assert property (@(posedge hclk) disable iff (!hresetn)
    (sleep_ff && sleep_d_ff && take_bit) |=> shift_ff == $past(nxt_shift))
    else $error("shifter stalled in low power");

  // Enabled pending event raises the line
  a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    (pend && int_ctl_ff[IC_GIE] && int_ctl_ff[IC_PERIPHERAL_INTERRUPT_ENABLE]) |=> irq_ff)
    else $error("interrupt missing with both enables");

  // No line without an enabled flag
  a_irq_needs_pend: assert property (@(posedge hclk) disable iff (!hresetn)
    !pend |=> !irq_ff)
    else $error("interrupt without enabled flag");

  // Inverted clock samples on the pin's fall
  a_clk_inv_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    (take_bit && line_ctl_ff[LC_CLK_INV]) |-> !sck_sync_ff[1] && sck_sync_ff[2])
    else $error("inverted clock sampled on wrong edge");

  // Plain clock samples on the pin's rise
  a_clk_plain_edge: assert property (@(posedge hclk) disable iff (!hresetn)
    (take_bit && !line_ctl_ff[LC_CLK_INV]) |-> sck_sync_ff[1] && !sck_sync_ff[2])
    else $error("plain clock sampled on wrong edge");

  // New bit enters with the chosen data sense
  a_data_inverted: assert property (@(posedge hclk) disable iff (!hresetn)
    take_bit |=> shift_ff[8] == ($past(sdat_sync_ff[1]) ^ $past(line_ctl_ff[LC_DATA_INV])))
    else $error("data sense not applied");

  // Older bits move toward bit zero
  a_lsb_first: assert property (@(posedge hclk) disable iff (!hresetn)
    take_bit |=> shift_ff[7:0] == $past(shift_ff[8:1]))
    else $error("shifter moved the wrong way");

  // Shifter frozen while receive is off
  a_no_shift_off: assert property (@(posedge hclk) disable iff (!hresetn)
    !rx_active |=> $stable(shift_ff))
    else $error("shifter moved while receive off");

  // Eight-bit words leave the ninth bit clear
  a_eight_no_ninth: assert property (@(posedge hclk) disable iff (!hresetn)
    (load_buf && !nine) |=> !received_ninth_bit_ff)
    else $error("ninth bit set in eight-bit mode");

  // Overrun keeps the unread word and flags it
  a_ovr_keeps_buf: assert property (@(posedge hclk) disable iff (!hresetn)
    ovr_set |=> ovr_ff && $stable(rxbuf_ff))
    else $error("overrun lost the unread word");

  // Buffer only changes on a load
  a_buf_stands: assert property (@(posedge hclk) disable iff (!hresetn)
    !load_buf |=> $stable(rxbuf_ff))
    else $error("buffer changed without a word");

  // No wake pulse while awake
  a_no_wake_awake: assert property (@(posedge hclk) disable iff (!hresetn)
    !sleep_ff |=> !wake_ff)
    else $error("wake pulse while not in low power");

  // Buffer read returns the stored byte, upper bits zero
  a_read_buf_data: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_buf |=> hrdata_ff == {24'h000000, $past(rxbuf_ff)})
    else $error("buffer read returned wrong data");

  // Single-receive bit alone never starts a word
  a_single_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (rcv_ctl_ff[RS_SINGLE] && !rcv_ctl_ff[RS_CONT]) |-> !take_bit)
    else $error("single-receive bit started reception");
endmodule

// *** bench/ssr_master.sv ***
// Purpose: behavioural synchronous master for the serial receiver
// Assumes: 400 ns shift clock, bit set up half a period ahead
// Notes: clock stands still between frames; data flips when released
`timescale 1ns/100ps
module ssr_master (
  output logic shift_clock_pin,
  output logic serial_data_pin
);
  logic idle_lvl = 1'b0;
  // Idle levels at time zero
  initial begin
    shift_clock_pin = 1'b0;
    serial_data_pin = 1'b1;
  end
  // Park the clock at the idle level of the chosen polarity
  task automatic park(input logic ci);
    idle_lvl = ci;
    shift_clock_pin = ci;
  endtask
  task automatic send(input logic [8:0] w, input int n, input logic di);
    for (int i = 0; i < n; i++) begin
      serial_data_pin = w[i] ^ di;
      #200 shift_clock_pin = ~idle_lvl;
      #200 shift_clock_pin = idle_lvl;
    end
    // Released line never shows a stale bit
    serial_data_pin = ~serial_data_pin;
  endtask
endmodule

// *** bench/ssr_top_tb.sv ***
// Purpose: self-checking bench for the serial receiver
// Assumes: one bus slave, hready fed back from hreadyout
// Notes: each scenario starts from a fresh reset
`timescale 1ns/100ps
module ssr_top_tb import ssr_pkg::*; ;
  logic hclk, hresetn, hwrite, hreadyout, hresp, irq, wake, low_power, sclk, sdat;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  int miscompares = 0;
  int checks = 0;
  int wakes = 0;
  ssr_top u_ssr_top (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .shift_clock_pin(sclk), .serial_data_pin(sdat),
    .irq(irq), .wake(wake), .low_power(low_power));
  ssr_master u_ssr_master (.shift_clock_pin(sclk), .serial_data_pin(sdat));
  // 20 MHz clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // Count wake pulses, which last only one cycle
  always @(posedge hclk) begin
    if (wake === 1'b1) wakes++;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Bounded wait for hready sampled high
  task automatic wrdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        miscompares++;
        results();
      end
      @(posedge hclk);
    end
  endtask
  // One single transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wrdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wrdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, {24'h0, e});
  endtask
  // Reset, park clock, program slave mode; receive enable written last
  task automatic setup(input logic [7:0] rs, input logic [7:0] ts, input logic [7:0] lc);
    hresetn <= 1'b0;
    u_ssr_master.park(lc[LC_CLK_INV]);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    wr(ADDR_LINE_CTL, lc);
    wr(ADDR_TX_STAT, ts);
    wr(ADDR_IRQ_EN, 8'h01);
    wr(ADDR_INT_CTL, 8'hc0);
    wr(ADDR_RCV_STAT, rs);
  endtask
  // Off-edge word, then sync and load latency
  task automatic rx(input logic [8:0] w, input int n, input logic di);
    #17;
    u_ssr_master.send(w, n, di);
    repeat (8) @(posedge hclk);
  endtask
  task automatic t_regs;
    setup(8'h00, 8'h00, 8'h00);
    chk(irq, 1'b0);
    rchk(ADDR_IRQ_STAT, REG_RESET);
    wr(ADDR_RCV_BUF, 8'h3c);
    rchk(ADDR_RCV_BUF, REG_RESET);
    wr(8'h40, 8'hff);
    rchk(8'h40, 8'h00);
    chk(hresp, 1'b0);
    wr(ADDR_RCV_STAT, 8'h07);
    rchk(ADDR_RCV_STAT, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_basic;
    setup(8'hb0, 8'h10, 8'h00);
    rx(9'h0a5, 8, 1'b0);
    chk(irq, 1'b1);
    rchk(ADDR_IRQ_STAT, 8'h01);
    rchk(ADDR_RCV_BUF, 8'ha5);
    rchk(ADDR_RCV_STAT, 8'hb0);
    wr(ADDR_IRQ_CLR, 8'h01);
    // Flag clears at data phase end; line follows one cycle later
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    rx(9'h03c, 8, 1'b0);
    rchk(ADDR_RCV_BUF, 8'h3c);
    $display("test basic done");
  endtask
  task automatic t_gate;
    setup(8'h80, 8'h10, 8'h00);
    rx(9'h0a5, 8, 1'b0);
    rchk(ADDR_IRQ_STAT, 8'h00);
    wr(ADDR_TX_STAT, 8'h90);
    wr(ADDR_RCV_STAT, 8'h90);
    rx(9'h0a5, 8, 1'b0);
    rchk(ADDR_IRQ_STAT, 8'h00);
    wr(ADDR_TX_STAT, 8'h10);
    rx(9'h0c3, 8, 1'b0);
    rchk(ADDR_RCV_BUF, 8'hc3);
    $display("test gate done");
  endtask
  task automatic t_inv;
    setup(8'hd0, 8'h10, 8'h30);
    rx(9'h15a, 9, 1'b1);
    rchk(ADDR_RCV_STAT, 8'hd1);
    rchk(ADDR_RCV_BUF, 8'h5a);
    rx(9'h0a5, 9, 1'b1);
    rchk(ADDR_RCV_STAT, 8'hd0);
    rchk(ADDR_RCV_BUF, 8'ha5);
    $display("test invert done");
  endtask
  task automatic t_ovr;
    setup(8'h90, 8'h10, 8'h00);
    rx(9'h011, 8, 1'b0);
    rx(9'h022, 8, 1'b0);
    rchk(ADDR_IRQ_STAT, 8'h03);
    rchk(ADDR_RCV_STAT, 8'h92);
    rchk(ADDR_RCV_BUF, 8'h11);
    wr(ADDR_RCV_STAT, 8'h80);
    rchk(ADDR_RCV_STAT, 8'h80);
    $display("test overrun done");
  endtask
  task automatic t_sleep;
    setup(8'h90, 8'h10, 8'h00);
    wr(ADDR_INT_CTL, 8'h00);
    wr(ADDR_POWER, 8'h01);
    @(posedge hclk);
    chk(low_power, 1'b1);
    wakes = 0;
    rx(9'h077, 8, 1'b0);
    chk(wakes, 1);
    chk(low_power, 1'b0);
    chk(irq, 1'b0);
    rchk(ADDR_RCV_BUF, 8'h77);
    wr(ADDR_INT_CTL, 8'h40);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0);
    wr(ADDR_INT_CTL, 8'hc0);
    repeat (2) @(posedge hclk);
    chk(irq, 1'b1);
    $display("test sleep done");
  endtask
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    t_regs();
    t_basic();
    t_gate();
    t_inv();
    t_ovr();
    t_sleep();
    results();
  end
  // Guard against a hang
  initial begin
    #3000000;
    miscompares++;
    results();
  end
endmodule
